// file: rtl/hsd_ctrl.sv
`timescale 1ns/1ps
// How it works
// (RULE1) each output follows its own enable bit in the control register.
// (RULE2) with enable and pwm gate both set the output follows the pwm pin.
// (RULE3) overtemperature shuts both outputs off and latches an event.
// (RULE4) thermal shutdown shows as all four status flags set at once.
// (RULE5) a latched thermal event reports source code 0010.
// (RULE6) irq goes low only when the high-side mask bit is set.
// (RULE7) after thermal shutdown a control write once cool re-enables.
// (RULE8) with shutdown enabled a high-voltage event shuts both outputs.
// (RULE9) after high-voltage shutdown a control write once clear re-enables.
// (RULE10) open-load flags sit on status bits 1 and 3 and follow the sense.
// (RULE11) current-limit flags sit on status bits 0 and 2.
// (RULE12) current limiting keeps the output on and raises no interrupt.
// (RULE13) outputs may stay enabled in sleep and stop modes.
// (RULE14) interrupts only arise in normal, normal request and stop modes.
// (RULE15) the pwm pin is synchronised before gating the outputs.
module hsd_ctrl
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire hsd_pkg::hsd_ctrl_s  high_side_control_reg,
  input  wire logic                ctrl_write,
  input  wire logic                high_side_irq_mask,
  input  wire logic                high_voltage_shutdown_enable,
  input  wire logic                isr_read,
  input  wire hsd_pkg::hsd_mode_e  mode,
  input  wire logic                pwm_input_pin,
  input  wire logic                over_temp,
  input  wire logic                high_voltage,
  input  wire hsd_pkg::hsd_sense_s sense_one,
  input  wire hsd_pkg::hsd_sense_s sense_two,
  output logic                     hs_one_on,
  output logic                     hs_two_on,
  output logic [3:0]               high_side_status_reg,
  output logic [3:0]               interrupt_source_reg,
  output logic                     irq_n
);
  import hsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state and next values

  // pwm pin synchroniser
  logic       pwm_meta;
  logic       pwm_sync;
  logic       next_pwm_meta;
  logic       next_pwm_sync;

  // control register image and shutdown latches
  hsd_ctrl_s  ctrl;
  hsd_ctrl_s  next_ctrl;
  logic       ot_off;
  logic       next_ot_off;
  logic       hv_off;
  logic       next_hv_off;

  // thermal event latch
  logic       ot_latched;
  logic       next_ot_latched;
  logic       irq_mode;

  // output drive
  logic       one_pwm_ok;
  logic       two_pwm_ok;
  logic       next_one_on;
  logic       next_two_on;

  // status and interrupt report
  logic [3:0] next_status;
  logic [3:0] next_source;
  logic       next_irq_n;

  ////////////////////////////////////////////////////////////////////////
  // pwm pin synchroniser

  // the pin is asynchronous to the host, so it passes two flops
  // before it may gate an output; only the second flop is used
  always_comb begin
    next_pwm_meta = pwm_input_pin; // RULE15
    next_pwm_sync = pwm_meta;      // RULE15
  end

  // synchroniser flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_meta <= 1'b0;
      pwm_sync <= 1'b0;
    end else begin
      pwm_meta <= next_pwm_meta;
      pwm_sync <= next_pwm_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control image and shutdown latches

  // the image takes every host write, even while shut down, so the
  // host settings are already in place when the drivers come back
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl = high_side_control_reg; // RULE1
    end
    // heat wins over a write in the same cycle
    next_ot_off = ot_off;
    if (over_temp) begin
      next_ot_off = 1'b1; // RULE3
    end else if (ctrl_write) begin
      next_ot_off = 1'b0; // RULE7
    end
    // a write while the supply is still high keeps the drivers off
    next_hv_off = hv_off;
    if (high_voltage && high_voltage_shutdown_enable) begin
      next_hv_off = 1'b1; // RULE8
    end else if (ctrl_write && !high_voltage) begin
      next_hv_off = 1'b0; // RULE9
    end
  end

  // image and shutdown flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl   <= HSD_CTRL_RST;
      ot_off <= 1'b0;
      hv_off <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      ot_off <= next_ot_off;
      hv_off <= next_hv_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // thermal event latch

  // only the awake modes may raise an event; entry into shutdown is
  // the event, so a long hot spell latches once
  always_comb begin
    irq_mode = (mode == HSD_MODE_NORMAL) ||
               (mode == HSD_MODE_NORMAL_REQ) ||
               (mode == HSD_MODE_STOP); // RULE14
    next_ot_latched = ot_latched;
    if (isr_read) begin
      next_ot_latched = 1'b0;
    end
    // a new event wins over a source read in the same cycle
    if (over_temp && !ot_off && high_side_irq_mask && irq_mode) begin
      next_ot_latched = 1'b1; // RULE3 RULE6
    end
  end

  // event flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ot_latched <= 1'b0;
    end else begin
      ot_latched <= next_ot_latched;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output drive

  // an enabled output follows the synchronised pin when gated
  always_comb begin
    one_pwm_ok  = !next_ctrl.output_one_pwm_gate || pwm_sync; // RULE2
    two_pwm_ok  = !next_ctrl.output_two_pwm_gate || pwm_sync; // RULE2
    next_one_on = next_ctrl.output_one_enable && one_pwm_ok; // RULE1
    next_two_on = next_ctrl.output_two_enable && two_pwm_ok; // RULE1
    // either shutdown overrides the enables
    if (next_ot_off || next_hv_off) begin
      next_one_on = 1'b0; // RULE3 RULE8
      next_two_on = 1'b0; // RULE3 RULE8
    end
  end
  // current limiting never turns an output off // RULE12
  // no mode gating: sleep and stop keep the outputs alive // RULE13
  // a user must know that a limited output may run hot until the
  // thermal shutdown takes it down

  // drive flops, the outputs come straight from here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_one_on <= 1'b0;
      hs_two_on <= 1'b0;
    end else begin
      hs_one_on <= next_one_on;
      hs_two_on <= next_two_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and interrupt report

  // live sense flags, all forced while thermally shut down
  always_comb begin
    next_status = '0;
    next_status[HSD_ST_CL1] = sense_one.current_limit; // RULE11
    next_status[HSD_ST_OL1] = sense_one.open_load;     // RULE10
    next_status[HSD_ST_CL2] = sense_two.current_limit; // RULE11
    next_status[HSD_ST_OL2] = sense_two.open_load;     // RULE10
    // all four flags together mark the thermal shutdown
    if (next_ot_off) begin
      next_status = HSD_ST_ALL; // RULE4
    end
    next_source = next_ot_latched ? HSD_SRC_HS : HSD_SRC_NONE; // RULE5
    next_irq_n  = !next_ot_latched; // RULE6 RULE12
  end

  // report flops, line idles high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_status_reg <= '0;
      interrupt_source_reg <= HSD_SRC_NONE;
      irq_n                <= 1'b1;
    end else begin
      high_side_status_reg <= next_status;
      interrupt_source_reg <= next_source;
      irq_n                <= next_irq_n;
    end
  end

endmodule

// file: rtl/hsd_pkg.sv
package hsd_pkg;

  // operating modes of the surrounding device
  typedef enum logic [3:0] {
    HSD_MODE_NORMAL     = 4'h1,
    HSD_MODE_NORMAL_REQ = 4'h2,
    HSD_MODE_STOP       = 4'h4,
    HSD_MODE_SLEEP      = 4'h8
  } hsd_mode_e;

  // status field positions
  localparam int HSD_ST_CL1 = 0;
  localparam int HSD_ST_OL1 = 1;
  localparam int HSD_ST_CL2 = 2;
  localparam int HSD_ST_OL2 = 3;

  localparam logic [3:0] HSD_SRC_HS   = 4'h2;
  localparam logic [3:0] HSD_SRC_NONE = 4'h0;
  localparam logic [3:0] HSD_ST_ALL   = 4'hf;

  // high-side control register image
  typedef struct packed {
    logic output_two_pwm_gate;
    logic output_one_pwm_gate;
    logic output_two_enable;
    logic output_one_enable;
  } hsd_ctrl_s;

  localparam hsd_ctrl_s HSD_CTRL_RST = '0;

  // analog sense inputs per channel
  typedef struct packed {
    logic open_load;
    logic current_limit;
  } hsd_sense_s;

endpackage

// file: test/high_side_driver_control_tb_top.sv
`timescale 1ns/1ps
module high_side_driver_control_tb_top;
  import hsd_pkg::*;
  `define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
  logic clk = 0, rst = 1, ctrl_write = 0, isr_read = 0, pwm_lvl = 0;
  logic over_temp = 0, high_voltage = 0, high_side_irq_mask = 0;
  logic high_voltage_shutdown_enable = 0, hs_one_on, hs_two_on, irq_n;
  logic [3:0] high_side_status_reg, interrupt_source_reg;
  hsd_ctrl_s high_side_control_reg = 4'h3;
  hsd_mode_e mode = HSD_MODE_NORMAL;
  hsd_sense_s sense_one = 2'h1, sense_two = 2'h2;
  wire pwm_input_pin;
  wire [10:0] obs = {hs_one_on, hs_two_on, high_side_status_reg,
    interrupt_source_reg, irq_n};
  int failures = 0, num_checks = 0, cycles = 0;
  hsd_ctrl hsd_ctrl_i (
    .clk                          (clk),
    .rst                          (rst),
    .high_side_control_reg        (high_side_control_reg),
    .ctrl_write                   (ctrl_write),
    .high_side_irq_mask           (high_side_irq_mask),
    .high_voltage_shutdown_enable (high_voltage_shutdown_enable),
    .isr_read                     (isr_read),
    .mode                         (mode),
    .pwm_input_pin                (pwm_input_pin),
    .over_temp                    (over_temp),
    .high_voltage                 (high_voltage),
    .sense_one                    (sense_one),
    .sense_two                    (sense_two),
    .hs_one_on                    (hs_one_on),
    .hs_two_on                    (hs_two_on),
    .high_side_status_reg         (high_side_status_reg),
    .interrupt_source_reg         (interrupt_source_reg),
    .irq_n                        (irq_n)
  );
  hsd_host hsd_host_i (
    .pwm_lvl       (pwm_lvl),
    .pwm_input_pin (pwm_input_pin)
  );
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) if (++cycles > 400) begin
    failures++;
    report_and_stop();
  end
  task automatic go(logic w, o, v, int n, logic [10:0] e);
    ctrl_write = w;
    over_temp = o;
    high_voltage = v;
    @(negedge clk) ctrl_write = 0;
    isr_read = 0;
    repeat (n) @(negedge clk);
    `CK("obs", e, obs)
  endtask
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // inputs move on the falling edge
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    go(1, 0, 0, 0, 11'h721);
    high_side_control_reg = 4'hf;
    go(1, 0, 0, 4, 11'h121);
    pwm_lvl = 1;
    go(0, 0, 0, 1, 11'h121);
    go(0, 0, 0, 0, 11'h721);
    high_side_irq_mask = 1;
    go(1, 1, 0, 2, 11'h1e4);
    go(0, 0, 0, 2, 11'h1e4);
    go(1, 0, 0, 0, 11'h724);
    isr_read = 1;
    go(0, 0, 0, 1, 11'h721);
    high_side_irq_mask = 0;
    go(0, 1, 0, 2, 11'h1e1);
    high_voltage_shutdown_enable = 1;
    go(1, 0, 1, 1, 11'h121);
    go(1, 0, 0, 0, 11'h721);
    mode = HSD_MODE_SLEEP;
    go(0, 0, 0, 1, 11'h721);
    high_side_irq_mask = 1;
    go(0, 1, 0, 1, 11'h1e1);
    report_and_stop();
  end
endmodule

// file: test/hsd_chk_checker.sv
`timescale 1ns/1ps
module hsd_chk
  import hsd_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ctrl_write,
  input wire logic       over_temp,
  input wire logic       high_voltage,
  input wire logic       high_voltage_shutdown_enable,
  input wire logic       high_side_irq_mask,
  input wire logic       hs_one_on,
  input wire logic       hs_two_on,
  input wire logic       irq_n,
  input wire logic [3:0] high_side_status_reg,
  input wire logic [3:0] interrupt_source_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shutdown, its hold and reporting
  off_a: assert property (
    over_temp |=> !hs_one_on && !hs_two_on) else $error("on when hot");
  flag_a: assert property (
    over_temp |=> high_side_status_reg == 4'hf) else $error("flags");
  src_a: assert property (
    !irq_n |-> interrupt_source_reg == 4'h2) else $error("source");
  mask_a: assert property (
    $fell(irq_n) |-> $past(high_side_irq_mask)) else $error("masked");
  cause_a: assert property (
    $fell(irq_n) |-> $past(over_temp)) else $error("irq cause");
  hot_wr_a: assert property (
    ctrl_write && over_temp |=> !hs_one_on) else $error("hot write");
  hv_a: assert property (
    high_voltage && high_voltage_shutdown_enable |=> !hs_one_on && !hs_two_on)
    else $error("hv on");
  hv_hold_a: assert property (
    $past(high_voltage && high_voltage_shutdown_enable) && !ctrl_write
    |=> !hs_one_on && !hs_two_on) else $error("hv hold");
endmodule
bind hsd_ctrl hsd_chk hsd_chk_i (.*);

// file: test/hsd_host.sv
`timescale 1ns/1ps
module hsd_host (
  input  wire logic pwm_lvl,
  output logic      pwm_input_pin
);
  // host pwm source, follows the level that the bench sets off the edge
  always_comb pwm_input_pin = pwm_lvl;
endmodule
